// ===== logic/pacdr_pkg.sv
// Package: register map, field layout and carrier types for the PHY slice
package pacdr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Bus constants
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0]  HSIZE_WORD    = 3'h2;
    localparam logic        HRESP_OKAY    = 1'b0;
    localparam int          REG_W         = 16;
    localparam int          ADDR_LO_W     = 8;

    // Register indices; byte address is four times the index
    localparam logic [7:0]  IDX_DIAG1     = 8'h00;
    localparam logic [7:0]  IDX_IDENT_HI  = 8'h06;
    localparam logic [7:0]  IDX_ADV       = 8'h08;
    localparam logic [7:0]  IDX_PARTNER   = 8'h0a;
    localparam logic [7:0]  ADDR_DIAG1    = 8'(IDX_DIAG1 * 4);
    localparam logic [7:0]  ADDR_IDENT_HI = 8'(IDX_IDENT_HI * 4);
    localparam logic [7:0]  ADDR_ADV      = 8'(IDX_ADV * 4);
    localparam logic [7:0]  ADDR_PARTNER  = 8'(IDX_PARTNER * 4);

    // Alias bank and interrupt registers
    localparam logic [7:0]  ADDR_ALIAS_ADV     = 8'h40;
    localparam logic [7:0]  ADDR_ALIAS_PARTNER = 8'h44;
    localparam logic [7:0]  ADDR_ALIAS_DIAG    = 8'h48;
    localparam logic [7:0]  ADDR_IRQ_STATUS    = 8'h50;
    localparam logic [7:0]  ADDR_IRQ_MASK      = 8'h54;

    // Identifier value is arbitrary
    localparam logic [15:0] IDENT_HIGH_DEFAULT = 16'h5a5a;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int          ADV_PAUSE_BIT  = 10;
    localparam int          ADV_F100_BIT   = 8;
    localparam int          ADV_H100_BIT   = 7;
    localparam int          ADV_F10_BIT    = 6;
    localparam int          ADV_H10_BIT    = 5;
    localparam int          SEL_MSB        = 4;
    localparam logic [4:0]  SEL_8023       = 5'h01;
    localparam logic [4:0]  PARTNER_LOW    = 5'h01;

    localparam int          DIAG_START_BIT  = 15;
    localparam int          DIAG_RES_MSB    = 14;
    localparam int          DIAG_RES_LSB    = 13;
    localparam int          DIAG_SHORT_BIT  = 12;
    localparam int          DIAG_CNT_MSB    = 8;
    localparam int          ALIAS_START_BIT = 12;
    localparam int          ALIAS_SHORT_BIT = 15;

    localparam logic [1:0]  RES_NORMAL = 2'h0;
    localparam logic [1:0]  RES_OPEN   = 2'h1;
    localparam logic [1:0]  RES_SHORT  = 2'h2;
    localparam logic [1:0]  RES_FAIL   = 2'h3;

    localparam int          IRQ_W           = 2;
    localparam int          IRQ_DIAG_BIT    = 0;
    localparam int          IRQ_PARTNER_BIT = 1;

    ////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic pause;
        logic f100;
        logic h100;
        logic f10;
        logic h10;
    } pacdr_ability_type;

    typedef struct packed {
        logic [1:0] result;
        logic       near_short;
        logic [8:0] fault_count;
    } pacdr_diag_type;

    localparam pacdr_ability_type ADV_RESET     = pacdr_ability_type'(5'h1f);
    localparam pacdr_ability_type PARTNER_RESET = pacdr_ability_type'(5'h00);
    localparam pacdr_diag_type    DIAG_RESET    = pacdr_diag_type'(12'h000);

    ////////////////////////////////////////////////////////////////////////
    // Layout helpers
    function automatic logic [15:0] pack_ability(input pacdr_ability_type a,
                                                 input logic [4:0] low);
        logic [15:0] w;
        w                = 16'h0000;
        w[ADV_PAUSE_BIT] = a.pause;
        w[ADV_F100_BIT]  = a.f100;
        w[ADV_H100_BIT]  = a.h100;
        w[ADV_F10_BIT]   = a.f10;
        w[ADV_H10_BIT]   = a.h10;
        w[SEL_MSB:0]     = low;
        return w;
    endfunction : pack_ability

    function automatic pacdr_ability_type unpack_ability(
        input logic [15:0] w);
        pacdr_ability_type a;
        a.pause = w[ADV_PAUSE_BIT];
        a.f100  = w[ADV_F100_BIT];
        a.h100  = w[ADV_H100_BIT];
        a.f10   = w[ADV_F10_BIT];
        a.h10   = w[ADV_H10_BIT];
        return a;
    endfunction : unpack_ability

    // Alias layout keeps the five bits packed at the bottom
    function automatic logic [15:0] pack_ability_alias(
        input pacdr_ability_type a);
        return {11'h000, a};
    endfunction : pack_ability_alias

    function automatic logic [15:0] pack_diag(input logic start,
                                              input pacdr_diag_type d,
                                              input int start_pos,
                                              input int short_pos);
        logic [15:0] w;
        w                              = 16'h0000;
        w[start_pos]                   = start;
        w[DIAG_RES_MSB:DIAG_RES_LSB]   = d.result;
        w[short_pos]                   = d.near_short;
        w[DIAG_CNT_MSB:0]              = d.fault_count;
        return w;
    endfunction : pack_diag

endpackage : pacdr_pkg

// ===== logic/pacdr_diag_ctl.sv
// Cable diagnostic start bit, result capture and completion event
`timescale 1ns/1ps

module pacdr_diag_ctl
    import pacdr_pkg::*;
(
    // Clock and reset
    input  wire logic           clock,
    input  wire logic           rstn,
    // Software side
    input  wire logic           start_req,
    output      logic           busy,
    output      pacdr_diag_type result,
    output      logic           done_evt,
    // Diagnostic engine side
    output      logic           start_pulse,
    input  wire logic           engine_done,
    input  wire pacdr_diag_type engine_result
);

    typedef enum logic {DIAG_IDLE, DIAG_RUN} pacdr_diag_state_type;

    pacdr_diag_state_type state_reg, state_next;
    pacdr_diag_type       result_reg, result_next;
    logic                 start_reg, start_next;
    logic                 done_reg, done_next;

    ////////////////////////////////////////////////////////////////////////
    // A start while running is ignored so results stay coherent
    always_comb begin
        state_next  = state_reg;
        result_next = result_reg;
        start_next  = 1'b0;
        done_next   = 1'b0;
        unique case (state_reg)
            DIAG_IDLE: begin
                if (start_req) begin
                    state_next = DIAG_RUN;
                    start_next = 1'b1;
                end
            end
            DIAG_RUN: begin
                if (engine_done) begin
                    state_next  = DIAG_IDLE;
                    result_next = engine_result;
                    done_next   = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_reg  <= DIAG_IDLE;
            result_reg <= DIAG_RESET;
            start_reg  <= 1'b0;
            done_reg   <= 1'b0;
        end else begin
            state_reg  <= state_next;
            result_reg <= result_next;
            start_reg  <= start_next;
            done_reg   <= done_next;
        end
    end

    assign busy        = (state_reg == DIAG_RUN);
    assign result      = result_reg;
    assign done_evt    = done_reg;
    assign start_pulse = start_reg;

    ////////////////////////////////////////////////////////////////////////
    start_self_clear_a: assert property (
        @(posedge clock) disable iff (!rstn)
        (busy && engine_done) |=> !busy && done_evt)
        else $error("start bit did not clear on test end");

    start_sets_a: assert property (
        @(posedge clock) disable iff (!rstn)
        (!busy && start_req) |=> busy && start_pulse ##1 !start_pulse)
        else $error("start request not taken");

    results_hold_a: assert property (
        @(posedge clock) disable iff (!rstn)
        (!busy && !start_req) |=> $stable(result_reg))
        else $error("results changed while idle");

    result_capture_a: assert property (
        @(posedge clock) disable iff (!rstn)
        (busy && engine_done) |=> result_reg == $past(engine_result))
        else $error("diagnostic fields not captured");

endmodule : pacdr_diag_ctl

// ===== logic/pacdr_regs.sv
// AHB-Lite register slice: identifier, advertisement, partner, diagnostic
`timescale 1ns/1ps

// Functional notes
// - Identifier-high word is read only; writes are ignored.
// - Advertisement bit 10 is writable pause advertise, reset one.
// - Advertisement bit 8 writable, 100 full-duplex advertise, reset one.
// - Advertisement bit 7 writable, 100 half-duplex advertise, reset one.
// - Advertisement bit 6 writable, 10 full-duplex advertise, reset one.
// - Advertisement bit 5 writable, 10 half-duplex advertise, reset one.
// - Partner bit 10 reports partner pause, read only, reset zero.
// - Partner bit 8 reports partner 100 full-duplex, read only, reset zero.
// - Partner bit 7 reports partner 100 half-duplex, read only, reset zero.
// - Partner bit 6 reports partner 10 full-duplex, read only, reset zero.
// - Partner bit 5 reports partner 10 half-duplex, read only, reset zero.
// - Writing one to diagnostic bit 15 starts test; hardware clears it.
// - Results valid once start bit reads zero; software waits for that.
// - Result field bits 14-13: normal, open, short, test failure.
// - Bit 12 flags a short closer than ten metres, read only.
// - Bits 8-0 give fault distance, about 0.4 metre per count.
module pacdr_regs
    import pacdr_pkg::*;
#(
    parameter logic [15:0] IDENT_HIGH = IDENT_HIGH_DEFAULT
)
(
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rstn,
    // AHB-Lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output      logic              hreadyout,
    output      logic [31:0]       hrdata,
    output      logic              hresp,
    // Auto-negotiation engine
    output      pacdr_ability_type adv_out,
    input  wire pacdr_ability_type partner_in,
    // Cable diagnostic engine
    output      logic              diag_start,
    input  wire logic              diag_done,
    input  wire pacdr_diag_type    diag_in,
    // Interrupt
    output      logic              irq
);

    typedef enum logic [1:0] {B_IDLE, B_WRITE, B_READ} pacdr_bus_state_type;

    ////////////////////////////////////////////////////////////////////////
    // Bus state
    pacdr_bus_state_type bus_reg, bus_next;
    logic [7:0]          addr_reg, addr_next;
    logic                hit_reg, hit_next;
    logic                ready_reg, ready_next;
    logic [31:0]         rdata_reg, rdata_next;
    logic                resp_reg;

    // Register state
    pacdr_ability_type   adv_reg, adv_next;
    pacdr_ability_type   partner_reg, partner_next;
    logic [IRQ_W-1:0]    status_reg, status_next;
    logic [IRQ_W-1:0]    mask_reg, mask_next;
    logic                irq_reg, irq_next;

    // Combinational helpers
    logic                accept;
    logic                wr_en;
    logic [15:0]         wdat;
    logic [15:0]         rd_word;
    logic                start_req;
    logic [IRQ_W-1:0]    irq_set;
    logic                diag_busy;
    logic                diag_done_evt;
    pacdr_diag_type      diag_result;

    assign accept = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign wr_en  = (bus_reg == B_WRITE) && hit_reg;
    assign wdat   = hwdata[REG_W-1:0];

    ////////////////////////////////////////////////////////////////////////
    // Reads take one wait state so a write just before is always seen
    always_comb begin
        bus_next   = bus_reg;
        addr_next  = addr_reg;
        hit_next   = hit_reg;
        ready_next = 1'b1;
        rdata_next = rdata_reg;
        unique case (bus_reg)
            B_IDLE, B_WRITE: begin
                if (accept) begin
                    addr_next = haddr[ADDR_LO_W-1:0];
                    hit_next  = (haddr[31:ADDR_LO_W] == '0) &&
                                (hsize == HSIZE_WORD);
                    if (hwrite) begin
                        bus_next = B_WRITE;
                    end else begin
                        bus_next   = B_READ;
                        ready_next = 1'b0;
                    end
                end else begin
                    bus_next = B_IDLE;
                end
            end
            B_READ: begin
                bus_next   = B_IDLE;
                rdata_next = {16'h0000, hit_reg ? rd_word : 16'h0000};
            end
            default: begin
                bus_next = B_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bus_reg   <= B_IDLE;
            addr_reg  <= 8'h00;
            hit_reg   <= 1'b0;
            ready_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
            resp_reg  <= HRESP_OKAY;
        end else begin
            bus_reg   <= bus_next;
            addr_reg  <= addr_next;
            hit_reg   <= hit_next;
            ready_reg <= ready_next;
            rdata_reg <= rdata_next;
            resp_reg  <= HRESP_OKAY;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped words read zero
    always_comb begin
        unique case (addr_reg)
            ADDR_IDENT_HI:      rd_word = IDENT_HIGH;
            ADDR_ADV: begin
                rd_word = pack_ability(adv_reg, SEL_8023);
            end
            ADDR_PARTNER:       rd_word = pack_ability(partner_reg,
                                                       PARTNER_LOW);
            ADDR_ALIAS_ADV:     rd_word = pack_ability_alias(adv_reg);
            ADDR_ALIAS_PARTNER: rd_word = pack_ability_alias(partner_reg);
            ADDR_DIAG1:         rd_word = pack_diag(diag_busy, diag_result,
                                              DIAG_START_BIT, DIAG_SHORT_BIT);
            ADDR_ALIAS_DIAG:    rd_word = pack_diag(diag_busy, diag_result,
                                              ALIAS_START_BIT,
                                              ALIAS_SHORT_BIT);
            ADDR_IRQ_STATUS:    rd_word = 16'(status_reg);
            ADDR_IRQ_MASK:      rd_word = 16'(mask_reg);
            default:            rd_word = 16'h0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Register updates; both bank addresses land on the same flops
    always_comb begin
        adv_next     = adv_reg;
        partner_next = partner_in;
        mask_next    = mask_reg;
        start_req    = 1'b0;
        irq_set      = '0;
        irq_set[IRQ_DIAG_BIT]    = diag_done_evt;
        irq_set[IRQ_PARTNER_BIT] = (partner_in != partner_reg);
        status_next  = status_reg;
        if (wr_en) begin
            unique case (addr_reg)
                ADDR_ADV: begin
                    adv_next = unpack_ability(wdat);
                end
                ADDR_ALIAS_ADV: begin
                    adv_next = pacdr_ability_type'(wdat[4:0]);
                end
                ADDR_DIAG1:      start_req = wdat[DIAG_START_BIT];
                ADDR_ALIAS_DIAG: start_req = wdat[ALIAS_START_BIT];
                ADDR_IRQ_STATUS: status_next = status_reg & ~wdat[IRQ_W-1:0];
                ADDR_IRQ_MASK:   mask_next = wdat[IRQ_W-1:0];
                default:         adv_next = adv_reg;
            endcase
        end
        // Set wins over a write-one clear in the same cycle
        status_next = status_next | irq_set;
        irq_next    = |(status_reg & mask_reg);
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            adv_reg     <= ADV_RESET;
            partner_reg <= PARTNER_RESET;
            status_reg  <= '0;
            mask_reg    <= '0;
            irq_reg     <= 1'b0;
        end else begin
            adv_reg     <= adv_next;
            partner_reg <= partner_next;
            status_reg  <= status_next;
            mask_reg    <= mask_next;
            irq_reg     <= irq_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Diagnostic sequencer
    pacdr_diag_ctl u_diag (
        .clock         (clock),
        .rstn          (rstn),
        .start_req     (start_req),
        .busy          (diag_busy),
        .result        (diag_result),
        .done_evt      (diag_done_evt),
        .start_pulse   (diag_start),
        .engine_done   (diag_done),
        .engine_result (diag_in)
    );

    assign hreadyout = ready_reg;
    assign hrdata    = rdata_reg;
    assign hresp     = resp_reg;
    assign adv_out   = adv_reg;
    assign irq       = irq_reg;

    ////////////////////////////////////////////////////////////////////////
    ident_read_a: assert property (
        @(posedge clock) disable iff (!rstn)
        (bus_reg == B_READ && hit_reg && addr_reg == ADDR_IDENT_HI)
        |=> hrdata == {16'h0000, IDENT_HIGH} && hreadyout)
        else $error("identifier word wrong");

    adv_pause_a: assert property (
        @(posedge clock) disable iff (!rstn)
        (wr_en && addr_reg == ADDR_ADV)
        |=> adv_out.pause == $past(hwdata[ADV_PAUSE_BIT]))
        else $error("pause advertise not written");

    adv_speed_a: assert property (
        @(posedge clock) disable iff (!rstn)
        (wr_en && addr_reg == ADDR_ADV)
        |=> {adv_out.f100, adv_out.h100, adv_out.f10, adv_out.h10} ==
            $past(hwdata[ADV_F100_BIT:ADV_H10_BIT]))
        else $error("speed advertise not written");

    adv_keep_a: assert property (
        @(posedge clock) disable iff (!rstn)
        !(wr_en && (addr_reg == ADDR_ADV || addr_reg == ADDR_ALIAS_ADV))
        |=> $stable(adv_out))
        else $error("advertise changed without write");

    sel_field_a: assert property (
        @(posedge clock) disable iff (!rstn)
        (bus_reg == B_READ && hit_reg && addr_reg == ADDR_ADV)
        |=> hrdata[SEL_MSB:0] == SEL_8023 && hrdata[15:11] == 5'h00)
        else $error("selector or unsupported bits wrong");

    partner_track_a: assert property (
        @(posedge clock) disable iff (!rstn)
        1'b1 |=> partner_reg == $past(partner_in))
        else $error("partner ability not tracked");

    alias_adv_a: assert property (
        @(posedge clock) disable iff (!rstn)
        (wr_en && addr_reg == ADDR_ALIAS_ADV)
        |=> adv_out == $past(hwdata[4:0]))
        else $error("alias write not shared");

    status_set_a: assert property (
        @(posedge clock) disable iff (!rstn)
        diag_done_evt |=> status_reg[IRQ_DIAG_BIT] ##1 1'b1)
        else $error("diagnostic event lost");

    irq_level_a: assert property (
        @(posedge clock) disable iff (!rstn)
        1'b1 |=> irq == $past(|(status_reg & mask_reg)))
        else $error("interrupt level wrong");

    resp_okay_a: assert property (
        @(posedge clock) disable iff (!rstn)
        hresp == HRESP_OKAY)
        else $error("response not okay");

    read_wait_a: assert property (
        @(posedge clock) disable iff (!rstn)
        (accept && !hwrite)
        |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");

    write_nowait_a: assert property (
        @(posedge clock) disable iff (!rstn)
        (accept && hwrite)
        |=> hreadyout)
        else $error("write stalled");

    partner_read_a: assert property (
        @(posedge clock) disable iff (!rstn)
        (bus_reg == B_READ && hit_reg && addr_reg == ADDR_PARTNER)
        |=> hrdata[ADV_PAUSE_BIT] == $past(partner_reg.pause))
        else $error("partner read wrong");

    diag_read_a: assert property (
        @(posedge clock) disable iff (!rstn)
        (bus_reg == B_READ && hit_reg && addr_reg == ADDR_DIAG1)
        |=> hrdata[DIAG_START_BIT] == $past(diag_busy))
        else $error("busy read wrong");

    partner_evt_a: assert property (
        @(posedge clock) disable iff (!rstn)
        (partner_in != partner_reg)
        |=> status_reg[IRQ_PARTNER_BIT])
        else $error("partner event lost");

    status_clear_a: assert property (
        @(posedge clock) disable iff (!rstn)
        (wr_en && addr_reg == ADDR_IRQ_STATUS && !(|irq_set))
        |=> status_reg == $past(status_reg & ~wdat[IRQ_W-1:0]))
        else $error("clear wrong");

    alias_start_a: assert property (
        @(posedge clock) disable iff (!rstn)
        (wr_en && addr_reg == ADDR_ALIAS_DIAG && !diag_busy
         && wdat[ALIAS_START_BIT]) |=> diag_busy)
        else $error("alias start lost");

    start_write_a: assert property (
        @(posedge clock) disable iff (!rstn)
        (wr_en && addr_reg == ADDR_DIAG1 && !diag_busy
         && wdat[DIAG_START_BIT]) |=> diag_start)
        else $error("start lost");

    alias_read_a: assert property (
        @(posedge clock) disable iff (!rstn)
        (bus_reg == B_READ && hit_reg && addr_reg == ADDR_ALIAS_ADV)
        |=> hrdata[4:0] == $past(adv_reg))
        else $error("alias read wrong");

endmodule : pacdr_regs

// ===== sim/pacdr_regs_bench.sv
// Self-checking bench for the PHY register slice
`timescale 1ns/1ps

module pacdr_regs_bench;
    import pacdr_pkg::*;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] data;
    } pacdr_note_type;

    logic              clock;
    logic              rstn;
    logic              hsel;
    logic [31:0]       haddr;
    logic [1:0]        htrans;
    logic              hwrite;
    logic [2:0]        hsize;
    logic [31:0]       hwdata;
    logic              hready;
    logic              hreadyout;
    logic [31:0]       hrdata;
    logic              hresp;
    pacdr_ability_type adv_out;
    pacdr_ability_type partner_in;
    logic              diag_start;
    logic              diag_done;
    pacdr_diag_type    diag_in;
    logic              irq;
    logic              rd_pend;
    int                n_errors;
    int                samples_checked;
    pacdr_note_type    exp_q[$];
    pacdr_note_type    note;

    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;

    pacdr_regs i_pacdr_regs (
        .clock      (clock),
        .rstn       (rstn),
        .hsel       (hsel),
        .haddr      (haddr),
        .htrans     (htrans),
        .hwrite     (hwrite),
        .hsize      (hsize),
        .hwdata     (hwdata),
        .hready     (hready),
        .hreadyout  (hreadyout),
        .hrdata     (hrdata),
        .hresp      (hresp),
        .adv_out    (adv_out),
        .partner_in (partner_in),
        .diag_start (diag_start),
        .diag_done  (diag_done),
        .diag_in    (diag_in),
        .irq        (irq)
    );

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Ready is stable between edges, so sample it at the falling edge before the rising edge
    task automatic wait_rdy;
        logic ok;
        ok = 1'b0;
        while (ok !== 1'b1) begin
            @(negedge clock);
            ok = hreadyout;
            @(posedge clock);
        end
    endtask : wait_rdy

    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hsize  <= HSIZE_WORD;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        exp_q.push_back('{a, {16'h0000, e}});
        bus(a, 1'b0, $urandom);
    endtask : rd

    task automatic finish_test;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////////////////
    // Read monitor: oldest note against each completed read
    always @(posedge clock) begin
        if (rd_pend && hreadyout === 1'b1) begin
            note = exp_q.pop_front();
            chk($sformatf("read %h", note.addr), note.data, hrdata);
            chk("hresp", 32'h0, {31'h0, hresp});
            rd_pend = 1'b0;
        end
        if (hsel && htrans == HTRANS_NONSEQ && !hwrite && hreadyout)
            rd_pend = 1'b1;
    end

    initial begin
        repeat (5000) @(posedge clock);
        n_errors++;
        finish_test();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        pacdr_diag_type    d;
        pacdr_diag_type    prev;
        pacdr_ability_type p;
        logic [31:0]       v;
        void'($urandom(47226));
        rstn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
        hwrite = 1'b0; hsize = HSIZE_WORD; hwdata = 32'h0;
        partner_in = 5'h00; diag_done = 1'b0; diag_in = 12'h000;
        rd_pend = 1'b0; n_errors = 0; samples_checked = 0;
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        chk("adv_out", 32'h1f, 32'(adv_out));
        rd(ADDR_IDENT_HI, IDENT_HIGH_DEFAULT);
        rd(ADDR_ADV, 16'h05e1);
        rd(ADDR_PARTNER, 16'h0001);
        rd(ADDR_DIAG1, 16'h0000);
        rd(8'h30, 16'h0000);
        wr(ADDR_IDENT_HI, 32'h0000ffff);
        wr(ADDR_PARTNER, 32'h0000ffff);
        rd(ADDR_IDENT_HI, IDENT_HIGH_DEFAULT);
        rd(ADDR_PARTNER, 16'h0001);
        // Odd passes write through the alias bank
        for (int i = 0; i < 4; i++) begin
            v = (i == 2) ? 32'h0 : $urandom;
            if (i[0]) wr(ADDR_ALIAS_ADV, v); else wr(ADDR_ADV, v);
            p = i[0] ? v[4:0] : {v[10], v[8:5]};
            rd(ADDR_ADV, {5'h00, p.pause, 1'b0, p[3:0], 5'h01});
            rd(ADDR_ALIAS_ADV, {11'h000, p});
            chk("adv_out", 32'(p), 32'(adv_out));
        end
        for (int i = 0; i < 3; i++) begin
            p = 5'($urandom);
            partner_in <= p;
            repeat (2) @(posedge clock);
            rd(ADDR_PARTNER, {5'h00, p.pause, 1'b0, p[3:0], 5'h01});
            rd(ADDR_ALIAS_PARTNER, {11'h000, p});
        end
        wr(ADDR_IRQ_STATUS, 32'h3);
        prev = 12'h000;
        // Every result code, mask alternating
        for (int i = 0; i < 4; i++) begin
            d = {i[1:0], 10'($urandom)};
            wr(ADDR_IRQ_MASK, {31'h0, i[0]});
            if (i[0]) wr(ADDR_ALIAS_DIAG, 32'h00001000);
            else wr(ADDR_DIAG1, 32'h00008000);
            @(negedge clock);
            chk("diag_start", 32'h1, {31'h0, diag_start});
            @(posedge clock);
            rd(ADDR_DIAG1, {1'b1, prev.result, prev.near_short, 3'h0,
                            prev.fault_count});
            diag_done <= 1'b1;
            diag_in   <= d;
            @(posedge clock);
            diag_done <= 1'b0;
            diag_in   <= ~d;
            @(posedge clock);
            @(posedge clock);
            @(negedge clock);
            chk("irq", {31'h0, i[0]}, {31'h0, irq});
            @(posedge clock);
            rd(ADDR_DIAG1, {1'b0, d.result, d.near_short, 3'h0,
                            d.fault_count});
            rd(ADDR_ALIAS_DIAG, {d.near_short, d.result, 4'h0,
                                 d.fault_count});
            rd(ADDR_IRQ_STATUS, 16'h0001);
            wr(ADDR_IRQ_STATUS, 32'h1);
            @(posedge clock);
            @(negedge clock);
            chk("irq", 32'h0, {31'h0, irq});
            @(posedge clock);
            prev = d;
        end
        // A stray completion while idle leaves the results alone
        diag_done <= 1'b1;
        @(posedge clock);
        diag_done <= 1'b0;
        rd(ADDR_DIAG1, {1'b0, prev.result, prev.near_short, 3'h0,
                        prev.fault_count});
        repeat (4) @(posedge clock);
        if (exp_q.size() != 0)
            n_errors++;
        finish_test();
    end

endmodule : pacdr_regs_bench
